/* core/pte_pkg.sv */
// package: constants, carriers and helpers of the pin task and event unit
// Behaviour
// - eight channels, each with config, tasks, event
// - each channel acts on its selected pin
// - set task drives the pin high
// - clear task drives the pin low
// - configurable task sets, clears, toggles or holds
// - event on rise, fall or any change
// - owned pin ignores the port's output value
// - disabled channel returns pin to the port
// - task priority: configurable, then clear, then set
// - polarity none with configurable task holds pin
// - entering task mode drives the initial level
// - combined event on rising edge of detect
// - clearing latch while bits remain regenerates edge
// - off request with detect high wakes by reset
// - detect works without any clock
// - event mode forces the pin to input
// - task mode forces the pin to output
// - disabled pin takes port direction and value
// - sense code: 0 off, 2 high, 3 low
package pte_pkg;
  localparam int NCH = 8;
  localparam int NPIN = 32;
  localparam int AW = 12;
  // register byte offsets
  localparam logic [11:0] OFS_TASK_OUT = 12'h000;
  localparam logic [11:0] OFS_TASK_SET = 12'h030;
  localparam logic [11:0] OFS_TASK_CLR = 12'h060;
  localparam logic [11:0] OFS_EVT_IN = 12'h100;
  localparam logic [11:0] OFS_EVT_PORT = 12'h17C;
  localparam logic [11:0] OFS_CONFIG = 12'h510;
  localparam logic [11:0] OFS_SENSE_LO = 12'h600;
  localparam logic [11:0] OFS_SENSE_HI = 12'h604;
  localparam logic [11:0] OFS_LATCH = 12'h608;
  localparam logic [11:0] OFS_PIN_IN = 12'h60C;
  // channel configuration field positions
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_PSEL_LSB = 8;
  localparam int CFG_POL_LSB = 16;
  localparam int CFG_INIT_BIT = 20;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] SENSE_RESET = 32'h0000_0000;
  // mode, polarity and sense encodings
  localparam logic [1:0] MODE_DIS = 2'h0;
  localparam logic [1:0] MODE_EVT = 2'h1;
  localparam logic [1:0] MODE_TASK = 2'h3;
  localparam logic [1:0] POL_NONE = 2'h0;
  localparam logic [1:0] POL_LOTOHI = 2'h1;
  localparam logic [1:0] POL_HITOLO = 2'h2;
  localparam logic [1:0] POL_TOGGLE = 2'h3;
  localparam logic [1:0] SENSE_HIGH = 2'h2;
  localparam logic [1:0] SENSE_LOW = 2'h3;

  typedef struct packed {
    logic init_level;
    logic [1:0] pol;
    logic [4:0] psel;
    logic [1:0] mode;
  } pte_cfg_t;

  typedef struct packed {
    logic t_out;
    logic t_clr;
    logic t_set;
  } pte_task_t;

  // word to channel configuration
  function automatic pte_cfg_t cfg_unpack(input logic [31:0] w);
    pte_cfg_t c;
    c.mode = w[CFG_MODE_LSB +: 2];
    c.psel = w[CFG_PSEL_LSB +: 5];
    c.pol = w[CFG_POL_LSB +: 2];
    c.init_level = w[CFG_INIT_BIT];
    return c;
  endfunction

  // channel configuration to word, other bits zero
  function automatic logic [31:0] cfg_pack(input pte_cfg_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CFG_MODE_LSB +: 2] = c.mode;
    w[CFG_PSEL_LSB +: 5] = c.psel;
    w[CFG_POL_LSB +: 2] = c.pol;
    w[CFG_INIT_BIT] = c.init_level;
    return w;
  endfunction

  // sense match of one pin level
  function automatic logic sense_hit(input logic [1:0] s, input logic lvl);
    return ((s == SENSE_HIGH) && lvl) || ((s == SENSE_LOW) && !lvl);
  endfunction

  // match of a with the word address of entry idx in an array at base
  function automatic logic is_reg(input logic [11:0] a, input logic [11:0] base, input int idx);
    return a == (base + 12'(idx * 4));
  endfunction
endpackage

/* core/pte_channel.sv */
// one channel: task driven output level and edge event
`timescale 1ns/100ps
`default_nettype none
module pte_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire pte_pkg::pte_cfg_t cfg,
  input wire pte_pkg::pte_task_t task_trig,
  input wire logic pin_level,
  output logic out_level,
  output logic event_pulse
);
  logic out_r;
  logic prev_r;
  logic [1:0] mode_prev_r;
  logic in_task;
  logic entering;
  logic rise;
  logic fall;

  assign in_task = cfg.mode == pte_pkg::MODE_TASK;
  assign entering = in_task && (mode_prev_r != pte_pkg::MODE_TASK);
  assign out_level = out_r;

  // output level: init on entry, then prioritised tasks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= 1'b0;
    end else if (entering) begin
      out_r <= cfg.init_level;
    end else if (in_task) begin
      if (task_trig.t_out) begin
        unique case (cfg.pol)
          pte_pkg::POL_NONE: out_r <= out_r;
          pte_pkg::POL_LOTOHI: out_r <= 1'b1;
          pte_pkg::POL_HITOLO: out_r <= 1'b0;
          pte_pkg::POL_TOGGLE: out_r <= ~out_r;
        endcase
      end else if (task_trig.t_clr) begin
        out_r <= 1'b0;
      end else if (task_trig.t_set) begin
        out_r <= 1'b1;
      end
    end
  end

  // previous pin sample and previous mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 1'b0;
      mode_prev_r <= pte_pkg::MODE_DIS;
    end else begin
      prev_r <= pin_level;
      mode_prev_r <= cfg.mode;
    end
  end

  // edge detect on the selected pin
  assign rise = pin_level && !prev_r;
  assign fall = !pin_level && prev_r;
  assign event_pulse = (cfg.mode == pte_pkg::MODE_EVT) &&
    (((cfg.pol == pte_pkg::POL_LOTOHI) && rise) ||
     ((cfg.pol == pte_pkg::POL_HITOLO) && fall) ||
     ((cfg.pol == pte_pkg::POL_TOGGLE) && (rise || fall)));

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rise_evt;
    (cfg.mode == pte_pkg::MODE_EVT && cfg.pol == pte_pkg::POL_LOTOHI && !pin_level) ##1
    (cfg.mode == pte_pkg::MODE_EVT && cfg.pol == pte_pkg::POL_LOTOHI && pin_level);
  endsequence

  a_event_rise: assert property (s_rise_evt |-> event_pulse)
    else $error("rising edge gave no event");
  a_set_high: assert property (in_task && !entering && task_trig.t_set &&
    !task_trig.t_clr && !task_trig.t_out |=> out_r)
    else $error("set task did not drive high");
  a_clear_prio: assert property (in_task && !entering && task_trig.t_clr &&
    !task_trig.t_out |=> !out_r)
    else $error("clear task did not win over set");
  a_none_hold: assert property (in_task && !entering && task_trig.t_out &&
    cfg.pol == pte_pkg::POL_NONE |=> $stable(out_r))
    else $error("polarity none changed the pin");
  a_toggle_flip: assert property (in_task && !entering && task_trig.t_out &&
    cfg.pol == pte_pkg::POL_TOGGLE |=> out_r != $past(out_r))
    else $error("toggle did not invert");
  a_init_level: assert property (entering |=> out_r == $past(cfg.init_level))
    else $error("task entry missed initial level");
endmodule
`default_nettype wire

/* core/pte_unit.sv */
// top of the pin task and event unit with its apb register slave
`timescale 1ns/100ps
`default_nettype none
module pte_unit #(
  parameter int NCH = pte_pkg::NCH,
  parameter int NPIN = pte_pkg::NPIN
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCH-1:0] task_out_trig,
  input wire logic [NCH-1:0] task_set_trig,
  input wire logic [NCH-1:0] clear_task_trig,
  output logic [NCH-1:0] event_in_pulse,
  output logic event_port_pulse,
  input wire logic [NPIN-1:0] gpio_out,
  input wire logic [NPIN-1:0] gpio_dir,
  input wire logic [NPIN-1:0] pin_in,
  output logic [NPIN-1:0] pin_out,
  output logic [NPIN-1:0] pin_oe,
  output logic detect,
  input wire logic sys_off_req,
  output logic off_wake_reset
);
  pte_pkg::pte_cfg_t cfg_r [NCH];
  pte_pkg::pte_task_t trig [NCH];
  logic [NCH-1:0] chan_out;
  logic [NCH-1:0] chan_evt;
  logic [NCH-1:0] chan_lvl;
  logic [NCH-1:0] events_in_r;
  logic events_port_r;
  logic [NPIN-1:0] pin_s_r;
  logic [63:0] sense_r;
  logic [NPIN-1:0] latch_r;
  logic [NPIN-1:0] hit_s;
  logic [NPIN-1:0] hit_live;
  logic detect_r;
  logic detect_d_r;
  logic wake_r;
  logic [NPIN-1:0] pin_out_r;
  logic [NPIN-1:0] pin_oe_r;
  logic [NPIN-1:0] pin_out_nxt;
  logic [NPIN-1:0] pin_oe_nxt;
  logic [NPIN-1:0] own_s;
  logic [31:0] prdata_r;
  logic [31:0] rd_nxt;
  logic err_r;
  logic err_nxt;
  logic wr_en;
  logic latch_clr;
  logic [NCH-1:0] wr_out;
  logic [NCH-1:0] wr_set;
  logic [NCH-1:0] wr_clr;
  logic [NCH-1:0] wr_evt;
  logic [NCH-1:0] wr_cfg;
  logic wr_port;

  // apb handshake: zero wait, error for unmapped addresses
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_r;
  assign prdata = prdata_r;
  assign wr_en = psel && penable && pwrite && !err_r;
  assign latch_clr = wr_en && (paddr == pte_pkg::OFS_LATCH);
  assign wr_port = wr_en && (paddr == pte_pkg::OFS_EVT_PORT);

  // per channel write strobes; tasks fire only on a written one
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      wr_out[c] = wr_en && pwdata[0] && pte_pkg::is_reg(paddr, pte_pkg::OFS_TASK_OUT, c);
      wr_set[c] = wr_en && pwdata[0] && pte_pkg::is_reg(paddr, pte_pkg::OFS_TASK_SET, c);
      wr_clr[c] = wr_en && pwdata[0] && pte_pkg::is_reg(paddr, pte_pkg::OFS_TASK_CLR, c);
      wr_evt[c] = wr_en && pte_pkg::is_reg(paddr, pte_pkg::OFS_EVT_IN, c);
      wr_cfg[c] = wr_en && pte_pkg::is_reg(paddr, pte_pkg::OFS_CONFIG, c);
    end
  end

  // read mux and address check, evaluated in the setup phase
  always_comb begin
    rd_nxt = 32'h0000_0000;
    err_nxt = 1'b1;
    for (int c = 0; c < NCH; c++) begin
      if (pte_pkg::is_reg(paddr, pte_pkg::OFS_TASK_OUT, c) ||
          pte_pkg::is_reg(paddr, pte_pkg::OFS_TASK_SET, c) ||
          pte_pkg::is_reg(paddr, pte_pkg::OFS_TASK_CLR, c)) begin
        err_nxt = 1'b0;
      end
      if (pte_pkg::is_reg(paddr, pte_pkg::OFS_EVT_IN, c)) begin
        rd_nxt = {31'h0000_0000, events_in_r[c]};
        err_nxt = 1'b0;
      end
      if (pte_pkg::is_reg(paddr, pte_pkg::OFS_CONFIG, c)) begin
        rd_nxt = pte_pkg::cfg_pack(cfg_r[c]);
        err_nxt = 1'b0;
      end
    end
    unique case (paddr)
      pte_pkg::OFS_EVT_PORT: begin
        rd_nxt = {31'h0000_0000, events_port_r};
        err_nxt = 1'b0;
      end
      pte_pkg::OFS_SENSE_LO: begin
        rd_nxt = sense_r[31:0];
        err_nxt = 1'b0;
      end
      pte_pkg::OFS_SENSE_HI: begin
        rd_nxt = sense_r[63:32];
        err_nxt = 1'b0;
      end
      pte_pkg::OFS_LATCH: begin
        rd_nxt = 32'(latch_r);
        err_nxt = 1'b0;
      end
      pte_pkg::OFS_PIN_IN: begin
        rd_nxt = 32'(pin_s_r);
        err_nxt = 1'b0;
      end
      default: ;
    endcase
  end

  // read data and error latched at the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else if (psel && !penable) begin
      prdata_r <= rd_nxt;
      err_r <= err_nxt;
    end
  end

  // channel configuration; pin select frozen while enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCH; c++) begin
        cfg_r[c] <= pte_pkg::cfg_unpack(pte_pkg::CFG_RESET);
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_cfg[c]) begin
          cfg_r[c] <= pte_pkg::cfg_unpack(pwdata);
          if (cfg_r[c].mode != pte_pkg::MODE_DIS) begin
            cfg_r[c].psel <= cfg_r[c].psel;
          end
        end
      end
    end
  end

  // pin capture; inputs are synchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s_r <= '0;
    end else begin
      pin_s_r <= pin_in;
    end
  end

  // channels: register or interconnect triggers, one pulse each
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign trig[c].t_out = wr_out[c] || task_out_trig[c];
    assign trig[c].t_clr = wr_clr[c] || clear_task_trig[c];
    assign trig[c].t_set = wr_set[c] || task_set_trig[c];
    assign chan_lvl[c] = pin_s_r[cfg_r[c].psel];
    pte_channel pte_channel_inst (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(cfg_r[c]),
      .task_trig(trig[c]),
      .pin_level(chan_lvl[c]),
      .out_level(chan_out[c]),
      .event_pulse(chan_evt[c])
    );
  end

  // sticky channel events, a raise wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      events_in_r <= '0;
      event_in_pulse <= '0;
    end else begin
      events_in_r <= chan_evt | (events_in_r & ~wr_evt);
      event_in_pulse <= chan_evt;
    end
  end

  // pin ownership: task drives, event reads, disabled gives back
  always_comb begin
    pin_out_nxt = gpio_out;
    pin_oe_nxt = gpio_dir;
    own_s = '0;
    for (int p = 0; p < NPIN; p++) begin
      for (int c = 0; c < NCH; c++) begin
        if (cfg_r[c].psel == p[4:0]) begin
          if (cfg_r[c].mode == pte_pkg::MODE_TASK) begin
            pin_out_nxt[p] = chan_out[c];
            pin_oe_nxt[p] = 1'b1;
            own_s[p] = 1'b1;
          end else if (cfg_r[c].mode == pte_pkg::MODE_EVT) begin
            own_s[p] = 1'b1;
            pin_out_nxt[p] = pin_out_r[p];
            pin_oe_nxt[p] = 1'b0;
          end
        end
      end
    end
  end

  // registered pin drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_r <= '0;
      pin_oe_r <= '0;
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end
  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;

  // per pin sense fields, two bits a pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_r <= {pte_pkg::SENSE_RESET, pte_pkg::SENSE_RESET};
    end else if (wr_en && paddr == pte_pkg::OFS_SENSE_LO) begin
      sense_r[31:0] <= pwdata;
    end else if (wr_en && paddr == pte_pkg::OFS_SENSE_HI) begin
      sense_r[63:32] <= pwdata;
    end
  end

  // sense matches: sampled for the latch, live for clockless wake
  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      hit_s[p] = pte_pkg::sense_hit(sense_r[2*p +: 2], pin_s_r[p]);
      hit_live[p] = pte_pkg::sense_hit(sense_r[2*p +: 2], pin_in[p]);
    end
  end

  // detect latch, write one to clear, a new match wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_r <= '0;
    end else begin
      latch_r <= hit_s | (latch_r & ~(latch_clr ? pwdata[NPIN-1:0] : '0));
    end
  end

  // detect level dips for one cycle on a clear so that a rise follows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_r <= 1'b0;
      detect_d_r <= 1'b0;
    end else begin
      detect_r <= (|latch_r) && !latch_clr;
      detect_d_r <= detect_r;
    end
  end

  // combined event on the rising edge of detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      events_port_r <= 1'b0;
      event_port_pulse <= 1'b0;
    end else begin
      event_port_pulse <= detect_r && !detect_d_r;
      events_port_r <= (detect_r && !detect_d_r) || (events_port_r && !wr_port);
    end
  end

  // wake level needs no clock: live pin matches or held latch
  assign detect = (|hit_live) || (|latch_r);

  // off request with detect high asks for a wakeup reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= sys_off_req && detect_r;
    end
  end
  assign off_wake_reset = wake_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_latch_clear_held;
    latch_clr && (|hit_s);
  endsequence

  a_latch_regen: assert property (s_latch_clear_held |=> !detect_r ##1 detect_r)
    else $error("latch clear did not regenerate detect edge");
  a_port_event: assert property ($rose(detect_r) |=> event_port_pulse && events_port_r)
    else $error("detect rise gave no port event");
  a_off_wake: assert property (sys_off_req && detect_r |=> off_wake_reset)
    else $error("off request with detect missed wake reset");
  a_event_sticky: assert property (events_in_r[0] && !wr_evt[0] |=> events_in_r[0])
    else $error("channel event flag dropped without clear");
  a_event_setwins: assert property (chan_evt[1] |=> events_in_r[1] && event_in_pulse[1])
    else $error("channel event lost");
  a_task_output: assert property (cfg_r[0].mode == pte_pkg::MODE_TASK && $stable(cfg_r[0])
    |=> pin_oe[$past(cfg_r[0].psel)] && pin_out[$past(cfg_r[0].psel)] == $past(chan_out[0]))
    else $error("task mode pin not driven by channel");
  a_event_input: assert property (cfg_r[0].mode == pte_pkg::MODE_EVT && $stable(cfg_r[0])
    |=> !pin_oe[$past(cfg_r[0].psel)])
    else $error("event mode pin not an input");
  a_unmapped_err: assert property (psel && !penable && err_nxt |=> pslverr || !penable)
    else $error("unmapped access without error");
  a_unmapped_quiet: assert property (psel && penable && err_r |=> $stable(sense_r))
    else $error("unmapped access changed the sense fields");

  // port event, wake and detect guards
  a_port_once: assert property (event_port_pulse |=> !event_port_pulse)
    else $error("port event pulse longer than one cycle");
  a_wake_drop: assert property (!sys_off_req |=> !off_wake_reset)
    else $error("wake reset without off request");
  a_detect_held: assert property (detect_r |-> detect)
    else $error("wake level low while detect is held");

  // latch bits stay until written off
  sequence s_latch_kept;
    (|latch_r) && !latch_clr;
  endsequence

  a_latch_hold: assert property (s_latch_kept |=> |latch_r)
    else $error("detect latch lost a bit without a clear");

  // a pin with no channel follows the port one edge later
  for (genvar p = 0; p < NPIN; p++) begin : g_pin_chk
    a_gpio_return: assert property (@(posedge pclk) disable iff (!presetn)
      !own_s[p] |=> pin_out[p] == $past(gpio_out[p]) && pin_oe[p] == $past(gpio_dir[p]))
      else $error("free pin not returned to the port");
  end
endmodule
`default_nettype wire

/* testbench/pte_pin_model.sv */
// pad model: the outside world seen through the pins
`timescale 1ns/100ps
`default_nettype none
module pte_pin_model (
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] ext_level,
  output logic [31:0] pin_in
);
  // pad level: unit drive wins, else the external source
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule
`default_nettype wire

/* testbench/pte_unit_tb_top.sv */
// self-checking bench of the pin task and event unit
`timescale 1ns/100ps
`default_nettype none
module pte_unit_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, detect;
  logic event_port_pulse, sys_off_req, off_wake_reset, cur;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, gpio_out, gpio_dir, pin_in, pin_out, pin_oe, ext_level;
  logic [7:0] task_out_trig, task_set_trig, clear_task_trig, event_in_pulse;
  logic [63:0] rd_q[$];
  logic [63:0] ev_q[$];
  logic [4:0] pin;
  int n_errors, cmp_count;

  pte_unit pte_unit_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .task_out_trig(task_out_trig), .task_set_trig(task_set_trig),
    .clear_task_trig(clear_task_trig), .event_in_pulse(event_in_pulse),
    .event_port_pulse(event_port_pulse), .gpio_out(gpio_out), .gpio_dir(gpio_dir),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .detect(detect),
    .sys_off_req(sys_off_req), .off_wake_reset(off_wake_reset));
  pte_pin_model pte_pin_model_inst (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_level(ext_level), .pin_in(pin_in));

  // clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic look(input int n);
    repeat (n) @(negedge pclk);
  endtask

  // apb transfer, held until pready is seen high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // access phase lasts until pready is seen high at a rising edge
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rd_q.push_back(64'(e));
    apb(a, 1'b0, 32'h0000_0000);
  endtask

  // one task pulse per kind, gpio values scrambled meanwhile
  task automatic fire(input int c, input logic [2:0] t);
    @(posedge pclk);
    task_out_trig <= 8'(t[2]) << c;
    clear_task_trig <= 8'(t[1]) << c;
    task_set_trig <= 8'(t[0]) << c;
    gpio_out <= $urandom();
    gpio_dir <= $urandom();
    @(posedge pclk);
    {task_out_trig, clear_task_trig, task_set_trig} <= 24'h000000;
  endtask

  function automatic logic [31:0] cw(input logic [1:0] m, input logic [4:0] p,
    input logic [1:0] pl, input logic i);
    return 32'(m) | (32'(p) << pte_pkg::CFG_PSEL_LSB) | (32'(pl) << pte_pkg::CFG_POL_LSB)
      | (32'(i) << pte_pkg::CFG_INIT_BIT);
  endfunction

  // expected level after one task combination {out, clear, set}
  function automatic logic nxt(input logic c, input logic [1:0] pl, input logic [2:0] t);
    if (t[2]) begin
      return (pl == pte_pkg::POL_NONE) ? c : (pl == pte_pkg::POL_LOTOHI) ? 1'b1 :
        (pl == pte_pkg::POL_HITOLO) ? 1'b0 : !c;
    end
    if (t[1]) return 1'b0;
    return t[0] ? 1'b1 : c;
  endfunction

  // monitor: each result takes the oldest note
  always @(negedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      check({pslverr, prdata}, rd_q.size() > 0 ? rd_q.pop_front() : '1);
    end
    if ({event_port_pulse, event_in_pulse} !== 9'h000) begin
      check({event_port_pulse, event_in_pulse}, ev_q.size() > 0 ? ev_q.pop_front() : '1);
    end
  end

  // watchdog
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end

  // main sequence
  initial begin
    logic [1:0] pol;
    logic [11:0] ca;
    {presetn, psel, penable, pwrite, sys_off_req} = 5'h00;
    {paddr, pwdata, gpio_out, gpio_dir, ext_level} = '0;
    {task_out_trig, task_set_trig, clear_task_trig} = 24'h000000;
    n_errors = 0;
    cmp_count = 0;
    void'($urandom(18));
    tick(10);
    presetn <= 1'b1;
    rd(pte_pkg::OFS_CONFIG + 12'h01C, {1'b0, pte_pkg::CFG_RESET});
    rd(pte_pkg::OFS_SENSE_HI, {1'b0, pte_pkg::SENSE_RESET});
    rd(12'h700, 33'h1_0000_0000);
    gpio_out <= $urandom();
    gpio_dir <= $urandom();
    look(3);
    check({pin_oe, pin_out}, {gpio_dir, gpio_out});
    // task mode: every channel, polarity and task combination
    for (int c = 0; c < 8; c++) begin
      pin = 5'(8 + 3 * c + $urandom_range(2));
      pol = 2'(c);
      cur = 1'($urandom());
      ca = 12'(4 * c);
      apb(pte_pkg::OFS_CONFIG + ca, 1'b1, cw(pte_pkg::MODE_TASK, pin, pol, cur));
      rd(pte_pkg::OFS_CONFIG + ca, {1'b0, cw(pte_pkg::MODE_TASK, pin, pol, cur)});
      look(3);
      check({pin_oe[pin], pin_out[pin]}, {1'b1, cur});
      for (int k = 1; k < 8; k++) begin
        cur = nxt(cur, pol, 3'(k));
        fire(c, 3'(k));
        look(3);
        check({pin_oe[pin], pin_out[pin]}, {1'b1, cur});
      end
      apb(pte_pkg::OFS_TASK_CLR + ca, 1'b1, 32'h0000_0001);
      look(3);
      check(pin_out[pin], 1'b0);
      apb(pte_pkg::OFS_TASK_SET + ca, 1'b1, 32'h0000_0001);
      look(3);
      check(pin_out[pin], 1'b1);
      apb(pte_pkg::OFS_TASK_OUT + ca, 1'b1, 32'h0000_0001);
      look(3);
      check(pin_out[pin], nxt(1'b1, pol, 3'h4));
      apb(pte_pkg::OFS_CONFIG + ca, 1'b1, cw(pte_pkg::MODE_DIS, pin, pol, cur));
      look(3);
      check({pin_oe[pin], pin_out[pin]}, {gpio_dir[pin], gpio_out[pin]});
    end
    // event mode: rise, fall and any change
    tick(1);
    gpio_out <= 32'h0000_0000;
    gpio_dir <= 32'hFFFF_FFFF;
    for (int c = 0; c < 8; c++) begin
      pin = 5'(8 + 3 * c + $urandom_range(2));
      pol = 2'(c % 3 + 1);
      ca = 12'(4 * c);
      apb(pte_pkg::OFS_CONFIG + ca, 1'b1, cw(pte_pkg::MODE_EVT, pin, pol, 1'b0));
      look(3);
      check(pin_oe[pin], 1'b0);
      tick(1);
      if (pol != pte_pkg::POL_HITOLO) ev_q.push_back(64'(8'h01 << c));
      ext_level[pin] <= 1'b1;
      tick(6);
      if (pol != pte_pkg::POL_LOTOHI) ev_q.push_back(64'(8'h01 << c));
      ext_level[pin] <= 1'b0;
      tick(6);
      rd(pte_pkg::OFS_EVT_IN + ca, 33'h0_0000_0001);
      apb(pte_pkg::OFS_EVT_IN + ca, 1'b1, 32'h0000_0000);
      rd(pte_pkg::OFS_EVT_IN + ca, 33'h0_0000_0000);
      apb(pte_pkg::OFS_CONFIG + ca, 1'b1, cw(pte_pkg::MODE_DIS, pin, pol, 1'b0));
    end
    // port detect: pin 2 senses high, pin 3 senses low
    tick(1);
    gpio_dir <= 32'h0000_0000;
    ext_level <= 32'h0000_0008;
    apb(pte_pkg::OFS_SENSE_LO, 1'b1, 32'h0000_00E0);
    apb(pte_pkg::OFS_EVT_PORT, 1'b1, 32'h0000_0001);
    ev_q.push_back(64'h100);
    ext_level[2] <= 1'b1;
    look(6);
    check(detect, 1'b1);
    rd(pte_pkg::OFS_LATCH, 33'h0_0000_0004);
    rd(pte_pkg::OFS_PIN_IN, 33'h0_0000_000C);
    rd(pte_pkg::OFS_EVT_PORT, 33'h0_0000_0001);
    apb(pte_pkg::OFS_EVT_PORT, 1'b1, 32'h0000_0001);
    ev_q.push_back(64'h100);
    apb(pte_pkg::OFS_LATCH, 1'b1, 32'h0000_0004);
    tick(6);
    ext_level[2] <= 1'b0;
    sys_off_req <= 1'b1;
    look(3);
    check({detect, off_wake_reset}, 2'h3);
    apb(pte_pkg::OFS_LATCH, 1'b1, 32'h0000_0004);
    look(3);
    check({detect, off_wake_reset}, 2'h0);
    ev_q.push_back(64'h100);
    tick(1);
    ext_level[3] <= 1'b0;
    #1;
    check(detect, 1'b1);
    tick(6);
    sys_off_req <= 1'b0;
    ext_level[3] <= 1'b1;
    apb(pte_pkg::OFS_SENSE_LO, 1'b1, 32'h0000_0000);
    apb(pte_pkg::OFS_LATCH, 1'b1, 32'h0000_0008);
    look(3);
    check(detect, 1'b0);
    check(64'(rd_q.size() + ev_q.size()), 64'h0);
    stop_test();
  end
endmodule
`default_nettype wire
